//--- common/sis_pkg.sv
// constants and state types shared by both ends of the serial interrupt link
// assumes both ends run their link logic on the same link clock, rising edge
// Overview of operation
// RL1: quiet start drives low one clock, releases
// RL2: no start while a cycle is active
// RL3: host extends start low to 4-8 clocks
// RL4: quiet mode, level change forces a start
// RL5: continuous mode, device never starts a cycle
// RL6: host may restart right after every stop
// RL7: mode changes only at stop, width measured
// RL8: frames counted from start rising edge, three phases
// RL9: sample phase drives low only for low level
// RL10: recovery drives high only after driven low
// RL11: turn-around phase always released
// RL12: report alike whoever started the cycle
// RL13: slot n samples 3n-1 clocks after edge
// RL14: slot 3 shares management interrupt and irq2
// RL15: slot 14 carries irq13
// RL16: only host drives the stop frame
// RL17: stop low 2 quiet, 3 continuous
// RL18: start earliest second clock after stop edge
// RL19: everything driven and sampled on rising edge
// RL20: reset releases line, selects continuous mode
// RL21: host runs first cycle, defaults before it
// RL22: host idles in continuous before reconfiguring
// RL23: management interrupt in slot only when enabled
// RL24: keep last levels, compare to detect changes
package sis_pkg;
  localparam int NUM_SLOTS = 16;
  localparam logic [4:0] UNUSED_SLOT = 5'h01;
  localparam logic [4:0] LAST_SLOT = 5'h10;
  localparam logic [1:0] PH_SAMPLE = 2'h0;
  localparam logic [1:0] PH_RECOVER = 2'h1;
  localparam logic [1:0] PH_TURN = 2'h2;
  localparam logic [3:0] STOP_W_QUIET = 4'h2;
  localparam logic [3:0] STOP_W_CONT = 4'h3;
  localparam logic [3:0] START_W_MIN = 4'h4;
  localparam logic [3:0] START_W_MAX = 4'h8;
  localparam logic MODE_RESET_QUIET = 1'b0;
  localparam logic [NUM_SLOTS:1] LEVEL_RESET = 16'hffff;
  // {slot enable, management interrupt, irq15..irq1}
  localparam logic [16:0] SRC_RESET = 17'h0ffff;
  localparam logic [5:0] CFG_RESET = 6'h04;
  typedef enum logic [1:0] {DV_IDLE, DV_START, DV_FRAME, DV_STOP} sis_dev_state_type;
  typedef enum logic [2:0] {H_IDLE, H_START, H_HIGH, H_FRAME, H_STOP, H_STOPHI} sis_host_state_type;
endpackage

//--- common/sis_link_if.sv
// the shared serial interrupt wire between host and device ends
// assumes both ends drive only from flip-flops on the link clock
`timescale 1ns/10ps
`default_nettype none
interface sis_link_if;
  logic dev_o;
  logic dev_oe_b;
  logic host_o;
  logic host_oe_b;
  logic serial_interrupt_line;
  // pulled-up wire, low whenever any end drives low
  assign serial_interrupt_line = ~((~dev_oe_b & ~dev_o) | (~host_oe_b & ~host_o));
  modport device (output dev_o, output dev_oe_b, input serial_interrupt_line);
  modport host (output host_o, output host_oe_b, input serial_interrupt_line);
endinterface
`default_nettype wire

//--- hw/sis_device.sv
// device end of the serial interrupt link: reports fifteen interrupt levels
// and the management interrupt slot by slot, all on the link clock
// assumes interrupt sources are asynchronous and the host runs the frames
`timescale 1ns/10ps
`default_nettype none
module sis_device
  import sis_pkg::*;
(
  input wire logic pci_clk,
  input wire logic rst_b,
  input wire logic [15:1] irq_level,
  input wire logic system_mgmt_interrupt_n,
  input wire logic smi_slot_enable,
  output logic link_quiet,
  output logic link_busy,
  sis_link_if.device link
);

  // source synchroniser stages
  logic [16:0] src_meta;
  logic [16:0] src_sync;

  // link tracking state
  sis_dev_state_type state;
  sis_dev_state_type next_state;
  logic prev_line;
  logic quiet;
  logic next_quiet;
  logic [4:0] slot;
  logic [4:0] next_slot;
  logic [1:0] ph;
  logic [1:0] next_ph;
  logic [3:0] width;
  logic [3:0] next_width;

  // pin drive registers
  logic pin_o;
  logic pin_oe_b;
  logic next_drive_low;
  logic next_drive_high;

  // last reported level of every slot
  logic [NUM_SLOTS:1] sent;

  // two-stage synchroniser for all asynchronous sources
  always_ff @(posedge pci_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_meta <= SRC_RESET;
      src_sync <= SRC_RESET;
    end else begin
      src_meta <= {smi_slot_enable, system_mgmt_interrupt_n, irq_level};
      src_sync <= src_meta;
    end
  end

  // management interrupt enters its slot only when enabled
  wire smi_in_slot = src_sync[16] & ~src_sync[15]; // RL23

  // slot map: slot 1 unused, slot n carries irq n-1
  wire [NUM_SLOTS:1] slot_val = {
    src_sync[14:2], // RL15
    src_sync[1] & ~smi_in_slot, // RL14
    src_sync[0],
    1'b1
  }; // RL13

  // any level differing from what was last reported
  wire pending = |(slot_val ^ sent); // RL24

  wire line = link.serial_interrupt_line;
  wire rise = line & ~prev_line;
  wire last_turn = (ph == PH_TURN) && (slot == LAST_SLOT);
  wire stop_quiet = (width == STOP_W_QUIET);
  wire stop_cont = (width == STOP_W_CONT);
  wire width_full = (width == 4'hf);
  wire drove_low_now = ~pin_oe_b & ~pin_o;
  wire enter_sample = (next_state == DV_FRAME) && (next_ph == PH_SAMPLE);
  wire enter_recover = (next_state == DV_FRAME) && (next_ph == PH_RECOVER);
  wire own_start = (state == DV_IDLE) && line && quiet && pending; // RL5

  // cycle tracking: start, data frames, stop measurement
  always_comb begin
    next_state = state;
    next_slot = slot;
    next_ph = ph;
    next_width = width;
    next_quiet = quiet;
    unique case (state)
      DV_IDLE: begin
        // idle is reached only at reset and at the first clock after a stop edge
        if (!line) begin
          next_state = DV_START; // RL12
        end else if (own_start) begin
          next_state = DV_START; // RL4
        end
      end
      DV_START: begin
        // count frames from the rising edge of the start pulse
        if (rise) begin
          next_state = DV_FRAME; // RL8
          next_slot = 5'h00;
          next_ph = PH_TURN;
        end
      end
      DV_FRAME: begin
        if (last_turn) begin
          next_state = DV_STOP;
          next_width = 4'h0;
        end else if (ph == PH_TURN) begin
          next_slot = slot + 5'h01; // RL13
          next_ph = PH_SAMPLE;
        end else begin
          next_ph = ph + 2'h1; // RL8
        end
      end
      DV_STOP: begin
        // host alone ends the cycle; measure its low width
        if (!line && !width_full) begin
          next_width = width + 4'h1; // RL16
        end
        if (rise) begin
          next_width = 4'h0;
          if (stop_quiet) begin
            next_quiet = 1'b1; // RL17
            next_state = DV_IDLE; // RL18
          end else if (stop_cont) begin
            next_quiet = 1'b0; // RL7
            next_state = DV_IDLE;
          end
        end
      end
    endcase
  end

  // drive only own start clock, sample lows and their recovery
  always_comb begin
    next_drive_low = 1'b0;
    next_drive_high = 1'b0;
    if (own_start) begin
      next_drive_low = 1'b1; // RL1
    end else if (enter_sample) begin
      next_drive_low = ~slot_val[next_slot]; // RL9
    end else if (enter_recover) begin
      next_drive_high = drove_low_now; // RL10
    end
  end

  // state registers, reset into continuous mode
  always_ff @(posedge pci_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= DV_IDLE;
      quiet <= MODE_RESET_QUIET; // RL20
      slot <= 5'h00;
      ph <= PH_TURN;
      width <= 4'h0;
      prev_line <= 1'b1;
    end else begin
      state <= next_state;
      quiet <= next_quiet;
      slot <= next_slot;
      ph <= next_ph;
      width <= next_width;
      prev_line <= line; // RL19
    end
  end

  // pin registers, released in reset and in turn-around
  always_ff @(posedge pci_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_o <= 1'b1;
      pin_oe_b <= 1'b1; // RL20
    end else begin
      pin_o <= next_drive_high;
      pin_oe_b <= ~(next_drive_low | next_drive_high); // RL11
    end
  end

  // remember the level put into each slot
  genvar n;
  generate
    for (n = 1; n <= NUM_SLOTS; n = n + 1) begin : g_sent
      wire load = enter_sample && (next_slot == 5'(n));
      always_ff @(posedge pci_clk or negedge rst_b) begin
        if (!rst_b) begin
          sent[n] <= LEVEL_RESET[n];
        end else if (load) begin
          sent[n] <= slot_val[n]; // RL24
        end
      end
    end
  endgenerate

  // slot 1 is never driven since its value is tied high
  assign link.dev_o = pin_o;
  assign link.dev_oe_b = pin_oe_b;
  assign link_quiet = quiet;
  assign link_busy = (state != DV_IDLE); // RL2

endmodule
`default_nettype wire

//--- hw/sis_host.sv
// host end of the serial interrupt link: runs start and stop frames on the
// link clock and hands each cycle's levels to the system clock domain
// assumes configuration inputs are quasi-static levels on clk
`timescale 1ns/10ps
`default_nettype none
module sis_host
  import sis_pkg::*;
#(
  parameter logic [NUM_SLOTS:1] DEFAULT_LEVEL = LEVEL_RESET
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pci_clk,
  input wire logic cfg_quiet,
  input wire logic cfg_back_to_back,
  input wire logic [3:0] cfg_start_width,
  input wire logic start_req,
  output logic [NUM_SLOTS:1] irq_state,
  output logic irq_update,
  sis_link_if.host link
);

  // clk domain side
  logic req_tgl;
  logic pub_meta;
  logic pub_sync;
  logic pub_seen;

  // link domain side
  logic [5:0] cfg_meta;
  logic [5:0] cfg_sync;
  logic req_meta;
  logic req_sync;
  logic req_seen;
  sis_host_state_type state;
  logic [3:0] left;
  logic [4:0] slot;
  logic [1:0] ph;
  logic [NUM_SLOTS:1] samp;
  logic [NUM_SLOTS:1] pub_word;
  logic pub_tgl;
  logic first_pend;
  logic req_pend;
  logic mode_quiet;
  logic pin_o;
  logic pin_oe_b;

  wire line = link.serial_interrupt_line; // RL19
  wire [3:0] cfg_w = cfg_sync[3:0];
  wire [3:0] start_w = (cfg_w < START_W_MIN) ? START_W_MIN : (cfg_w > START_W_MAX) ? START_W_MAX : cfg_w;
  wire req_evt = req_sync ^ req_seen;
  wire want_start = first_pend | req_pend | (~mode_quiet & cfg_sync[4]);
  wire take_dev = (state == H_IDLE) && !line;
  wire take_own = (state == H_IDLE) && line && want_start;
  wire [3:0] stop_w = cfg_sync[5] ? STOP_W_QUIET : STOP_W_CONT;

  // request toggle and level sync on the clk side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_tgl <= 1'b0;
      pub_meta <= 1'b0;
      pub_sync <= 1'b0;
      pub_seen <= 1'b0;
      irq_state <= DEFAULT_LEVEL; // RL21
      irq_update <= 1'b0;
    end else begin
      req_tgl <= req_tgl ^ start_req;
      pub_meta <= pub_tgl;
      pub_sync <= pub_meta;
      pub_seen <= pub_sync;
      irq_update <= pub_sync ^ pub_seen;
      if (pub_sync ^ pub_seen) begin
        irq_state <= pub_word;
      end
    end
  end

  // synchronisers into the link domain
  always_ff @(posedge pci_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_meta <= CFG_RESET;
      cfg_sync <= CFG_RESET;
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      cfg_meta <= {cfg_quiet, cfg_back_to_back, cfg_start_width};
      cfg_sync <= cfg_meta;
      req_meta <= req_tgl;
      req_sync <= req_meta;
      req_seen <= req_sync;
    end
  end

  // link sequencer: start, frames, stop
  always_ff @(posedge pci_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= H_IDLE;
      left <= 4'h0;
      slot <= 5'h00;
      ph <= PH_TURN;
      samp <= DEFAULT_LEVEL;
      pub_word <= DEFAULT_LEVEL;
      pub_tgl <= 1'b0;
      first_pend <= 1'b1; // RL21
      req_pend <= 1'b0;
      mode_quiet <= MODE_RESET_QUIET;
      pin_o <= 1'b1;
      pin_oe_b <= 1'b1;
    end else begin
      req_pend <= (req_pend & ~take_own & ~take_dev) | req_evt;
      pin_o <= 1'b0;
      pin_oe_b <= 1'b1;
      unique case (state)
        H_IDLE: begin
          if (take_dev || take_own) begin
            state <= H_START;
            first_pend <= 1'b0;
            left <= take_dev ? start_w - 4'h1 : start_w; // RL3
            pin_oe_b <= 1'b0;
          end
        end
        H_START: begin
          pin_oe_b <= 1'b0;
          if (left == 4'h1) begin
            state <= H_HIGH;
            pin_o <= 1'b1;
          end else begin
            left <= left - 4'h1;
          end
        end
        H_HIGH: begin
          state <= H_FRAME;
          slot <= 5'h00;
          ph <= PH_TURN;
        end
        H_FRAME: begin
          if (ph == PH_SAMPLE) begin
            samp[slot] <= line; // RL13
          end
          if ((ph == PH_TURN) && (slot == LAST_SLOT)) begin
            state <= H_STOP; // RL16
            left <= stop_w; // RL17
            pin_oe_b <= 1'b0;
          end else if (ph == PH_TURN) begin
            slot <= slot + 5'h01;
            ph <= PH_SAMPLE;
          end else begin
            ph <= ph + 2'h1;
          end
        end
        H_STOP: begin
          pin_oe_b <= 1'b0;
          if (left == 4'h1) begin
            state <= H_STOPHI;
            pin_o <= 1'b1;
            mode_quiet <= cfg_sync[5]; // RL7
          end else begin
            left <= left - 4'h1;
          end
        end
        H_STOPHI: begin
          // restart earliest at the next idle edge, two clocks after the stop edge
          state <= H_IDLE; // RL6
          pub_word <= samp;
          pub_tgl <= ~pub_tgl;
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  assign link.host_o = pin_o;
  assign link.host_oe_b = pin_oe_b;

endmodule
`default_nettype wire

//--- tb/sis_link_chk.sv
// checker for the serial interrupt wire between host and device ends
// assumes it watches the link interface signals on the link clock
`timescale 1ns/10ps
`default_nettype none
module sis_link_chk (
  input wire logic pci_clk,
  input wire logic rst_b,
  input wire logic dev_o,
  input wire logic dev_oe_b,
  input wire logic host_o,
  input wire logic host_oe_b,
  input wire logic serial_interrupt_line
);
  logic line_q;
  logic in_cyc;
  logic quiet;
  logic [3:0] low_cnt;
  logic [5:0] idx;
  // decoded wire events; recovery highs inside the frames are not start or stop edges
  wire logic rise = serial_interrupt_line & ~line_q;
  wire logic start_rise = rise & ~in_cyc;
  wire logic stop_rise = rise & in_cyc & (idx >= 6'h32);
  wire logic dev_low = ~dev_oe_b & ~dev_o;
  wire logic dev_high = ~dev_oe_b & dev_o;
  wire logic host_low = ~host_oe_b & ~host_o;
  // low width, position in cycle and next mode, seen from the wire
  always_ff @(posedge pci_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_q <= 1'b1;
      in_cyc <= 1'b0;
      quiet <= 1'b0;
      low_cnt <= 4'h0;
      idx <= 6'h00;
    end else begin
      line_q <= serial_interrupt_line;
      low_cnt <= serial_interrupt_line ? 4'h0 : (low_cnt == 4'hf ? low_cnt : low_cnt + 4'h1);
      idx <= start_rise ? 6'h01 : (idx == 6'h3f ? idx : idx + 6'h01);
      in_cyc <= start_rise ? 1'b1 : (stop_rise ? 1'b0 : in_cyc);
      quiet <= stop_rise ? (low_cnt == 4'h2) : quiet;
    end
  end
  default clocking cb @(posedge pci_clk); endclocking
  default disable iff (!rst_b);
  rst_release_a: assert property ($rose(rst_b) |-> dev_oe_b && host_oe_b)
    else $error("wire driven at reset release");
  start_one_a: assert property (dev_low && !in_cyc |=> dev_oe_b)
    else $error("device start not released after one clock");
  quiet_only_a: assert property (dev_low && !in_cyc |-> quiet)
    else $error("device start outside quiet mode");
  slot_place_a: assert property (dev_low && in_cyc |-> idx % 3 == 2 && idx >= 5 && idx <= 47)
    else $error("device low outside its sample clocks");
  recover_a: assert property (dev_low && in_cyc |=> dev_high)
    else $error("no recovery high after sample low");
  high_after_low_a: assert property (dev_high |-> $past(dev_low) ##1 dev_oe_b)
    else $error("device high without low or not released");
  stop_place_a: assert property (host_low && in_cyc |-> idx >= 50 && idx <= 52)
    else $error("host low inside data frames");
  stop_width_a: assert property (stop_rise |-> low_cnt == 4'h2 || low_cnt == 4'h3)
    else $error("stop width not two or three");
  start_width_a: assert property (start_rise |-> low_cnt >= 4'h4 && low_cnt <= 4'h8)
    else $error("start width outside four to eight");
  stop_gap_a: assert property (stop_rise |=> serial_interrupt_line)
    else $error("start too soon after stop");
  no_clash_a: assert property (dev_oe_b || host_oe_b)
    else $error("both ends drive the wire");
  cover property (dev_low && !in_cyc);
  cover property (stop_rise && low_cnt == 4'h2);
  cover property (dev_low && in_cyc && idx == 6'h08);
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench: host and device ends joined over one link interface
// assumes a 10 ns system clock and an unrelated 12 ns link clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sis_pkg::*;
  typedef struct packed {
    logic [15:1] lvl;
    logic smi_n;
    logic smi_en;
    logic [3:0] width;
    logic [NUM_SLOTS:1] exp;
  } sis_row_type;
  logic clk = 1'b0;
  logic pci_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:1] irq_level = 15'h7fff;
  logic smi_n = 1'b1;
  logic smi_en = 1'b0;
  logic cfg_quiet = 1'b0;
  logic cfg_b2b = 1'b0;
  logic [3:0] cfg_width = 4'h4;
  logic start_req = 1'b0;
  logic link_quiet;
  logic link_busy;
  logic [NUM_SLOTS:1] irq_state;
  logic irq_update;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int updates = 0;
  // levels, management interrupt, slot enable, start width, expected slot word
  sis_row_type rows [6] = '{'{15'h7fff, 1'b1, 1'b0, 4'h4, 16'hffff}, '{15'h0000, 1'b1, 1'b1, 4'h5, 16'h0001},
    '{15'h5555, 1'b0, 1'b1, 4'h6, 16'haaab}, '{15'h2aaa, 1'b0, 1'b1, 4'h7, 16'h5551},
    '{15'h2aaa, 1'b0, 1'b0, 4'h8, 16'h5555}, '{15'h6fff, 1'b1, 1'b0, 4'h9, 16'hdfff}};
  // clocks
  always #5 clk = ~clk;
  always #6 pci_clk = ~pci_clk;
  sis_link_if sis_link_if_i ();
  sis_device sis_device_i (.pci_clk(pci_clk), .rst_b(rst_b), .irq_level(irq_level),
    .system_mgmt_interrupt_n(smi_n), .smi_slot_enable(smi_en), .link_quiet(link_quiet),
    .link_busy(link_busy), .link(sis_link_if_i.device));
  sis_host sis_host_i (.clk(clk), .rst_b(rst_b), .pci_clk(pci_clk), .cfg_quiet(cfg_quiet),
    .cfg_back_to_back(cfg_b2b), .cfg_start_width(cfg_width), .start_req(start_req),
    .irq_state(irq_state), .irq_update(irq_update), .link(sis_link_if_i.host));
  sis_link_chk sis_link_chk_i (.pci_clk(pci_clk), .rst_b(rst_b), .dev_o(sis_link_if_i.dev_o),
    .dev_oe_b(sis_link_if_i.dev_oe_b), .host_o(sis_link_if_i.host_o), .host_oe_b(sis_link_if_i.host_oe_b),
    .serial_interrupt_line(sis_link_if_i.serial_interrupt_line));
  // slot word a row should give: slot1 pulled high, slot3 shared
  function automatic logic [NUM_SLOTS:1] expect_word(input sis_row_type r);
    expect_word = {r.lvl, 1'b1};
    expect_word[3] = r.lvl[2] & (r.smi_n | ~r.smi_en);
  endfunction
  task automatic check(input logic [NUM_SLOTS:1] seen, input logic [NUM_SLOTS:1] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // pulse and word are looked at half a cycle after the edge that launches them
  task automatic wait_update(output logic got);
    got = 1'b0;
    for (int i = 0; i < 300 && !got; i++) begin
      @(negedge clk);
      got = (irq_update === 1'b1);
    end
  endtask
  task automatic request;
    @(negedge clk);
    start_req = 1'b1;
    @(negedge clk);
    start_req = 1'b0;
  endtask
  task automatic results;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // update counter and hang guard
  always @(negedge clk) begin
    cycles++;
    if (irq_update === 1'b1) updates++;
    if (cycles == 10000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    logic got;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    wait_update(got);
    check({15'h0, got}, 16'h0001);
    check(irq_state, 16'hffff);
    foreach (rows[i]) begin
      irq_level = rows[i].lvl;
      smi_n = rows[i].smi_n;
      smi_en = rows[i].smi_en;
      cfg_width = rows[i].width;
      repeat (150) @(negedge clk);
      request();
      wait_update(got);
      check({15'h0, got}, 16'h0001);
      check(irq_state, expect_word(rows[i]));
      check(irq_state, rows[i].exp);
    end
    // quiet mode: a level change alone brings a cycle
    cfg_quiet = 1'b1;
    request();
    wait_update(got);
    repeat (20) @(negedge clk);
    check({15'h0, link_quiet}, 16'h0001);
    irq_level = 15'h7ffe;
    wait_update(got);
    check(irq_state, 16'hfffd);
    // continuous mode: the device stays passive
    cfg_quiet = 1'b0;
    request();
    wait_update(got);
    repeat (20) @(negedge clk);
    check({15'h0, link_quiet}, 16'h0000);
    updates = 0;
    irq_level = 15'h7fff;
    repeat (200) @(negedge clk);
    check(16'(updates), 16'h0000);
    request();
    wait_update(got);
    check(irq_state, 16'hffff);
    // host restarts after every stop
    cfg_b2b = 1'b1;
    request();
    updates = 0;
    repeat (400) @(negedge clk);
    cfg_b2b = 1'b0;
    check({15'h0, updates >= 4}, 16'h0001);
    repeat (200) @(negedge clk);
    // reset in mid-cycle
    irq_level = 15'h0fff;
    repeat (150) @(negedge clk);
    request();
    repeat (30) @(negedge clk);
    check({15'h0, link_busy}, 16'h0001);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    check({13'h0, link_quiet, link_busy, sis_link_if_i.serial_interrupt_line}, 16'h0001);
    check(irq_state, 16'hffff);
    // release away from a link clock edge
    @(posedge pci_clk);
    @(negedge clk);
    rst_b = 1'b1;
    wait_update(got);
    check({15'h0, got}, 16'h0001);
    results();
  end
endmodule
`default_nettype wire
